// File: common/rpcc_pkg.sv
package rpcc_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned STARTUP_MS    = 100;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_CYC   = STARTUP_MS * 1000000 / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ERRCNT = 8'h08;
  localparam logic [7:0] OFS_TRAP   = 8'h0c;
  // Control register bits
  localparam int CTRL_SEL_MAIN = 0;
  localparam int CTRL_UNIT_RST = 1;
  localparam int CTRL_CNT_CLR  = 2;
  localparam int CTRL_TRAP_EN  = 3;
  // Trap flag bits
  localparam int TRAP_LOSS = 0;
  localparam int TRAP_CHG  = 1;
  // Config switch bank bits
  localparam int CFG_RATE_E3  = 0;
  localparam int CFG_TX_HIGH  = 1;
  localparam int CFG_AIS_CHG  = 3;
  localparam int CFG_NO_INPUT = 4;
  // Input state codes
  localparam logic [1:0] IN_ABSENT  = 2'h0;
  localparam logic [1:0] IN_PRESENT = 2'h1;
  localparam logic [1:0] IN_FRAMED  = 2'h2;
  localparam logic [1:0] IN_AIS     = 2'h3;
  // Reset values
  localparam logic        TRAP_EN_RST = 1'b0;
  localparam logic [15:0] ERRCNT_RST  = 16'h0000;
  // Changeover states
  typedef enum logic [3:0] {
    RPCC_INIT  = 4'b0001,
    RPCC_STBY  = 4'b0010,
    RPCC_CLAIM = 4'b0100,
    RPCC_MAIN  = 4'b1000
  } rpcc_state_t;
  // Line monitor results
  typedef struct packed {
    logic       present;  // Valid input present
    logic       framed;   // Input framed
    logic       ais;      // Alarm indication in input
    logic       ts_found; // Transport stream payload seen
    logic [1:0] pkt_len;  // 0 none, 1 = 188, 2 = 204, 3 indeterminate
    logic       fec_seen; // Parity bytes seen
    logic       fec_err;  // One-cycle error pulse
  } rpcc_line_t;
  // Handshake with the partner card
  typedef struct packed {
    logic main;  // Card is main
    logic req;   // Card asks to become main
    logic fault; // Card input faulty
  } rpcc_link_t;
endpackage : rpcc_pkg

// File: design/rpcc_ctrl.sv
`timescale 1ns/1ns
module rpcc_ctrl
  import rpcc_pkg::*;
#(
  parameter int unsigned DB_CYC = DEBOUNCE_CYC,
  parameter int unsigned SU_CYC = STARTUP_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Front panel and rear pins
  input  wire logic        i_change_pb_n,
  input  wire logic        i_allow_sw,
  input  wire logic        i_ext_req_n,
  input  wire logic        i_pwr_ok,
  input  wire logic        i_slot_hi,
  input  wire logic [7:0]  i_config_switch_bank,
  // Partner card
  input  wire logic        i_partner_present_n,
  input  wire rpcc_link_t  i_partner,
  output rpcc_link_t       o_link,
  // Line monitor
  input  wire rpcc_line_t  i_line,
  // Indicators, alarms, output path
  output logic             o_led_in_service,
  output logic             o_led_standby,
  output logic             o_led_data_loss,
  output logic             o_led_ais,
  output logic             o_gen_alarm_n,
  output logic             o_pwr_alarm_n,
  output logic             o_tally_main_n,
  output logic             o_sel_own_input,
  output logic             o_tx_enable,
  output logic             o_tx_ais,
  output logic             o_trap_event
);
  // Synchronised pin positions
  localparam int S_PB    = 0;
  localparam int S_ALLOW = 1;
  localparam int S_EXT   = 2;
  localparam int S_PWR   = 3;
  localparam int S_SLOT  = 4;
  localparam int S_PRES  = 5;
  localparam int S_PMAIN = 6;
  localparam int S_PREQ  = 7;
  localparam int S_PFLT  = 8;
  localparam int S_CFG   = 9;
  localparam int SYN_W   = 17;
  localparam int DB_W    = $clog2(DB_CYC + 1);
  localparam int SU_W    = $clog2(2 * SU_CYC + 1);

  // Module state apart from the reset synchroniser
  typedef struct packed {
    logic [SYN_W-1:0]     s1;         // First synchroniser stage
    logic [SYN_W-1:0]     s2;         // Second synchroniser stage
    logic [2:0]           db_val;     // Debounced button, allow, ext
    logic [2:0][DB_W-1:0] db_cnt;     // Debounce counters
    logic                 pb_prev;    // Button edge detect
    rpcc_state_t          st;         // Changeover state
    logic [SU_W-1:0]      wait_cnt;   // Power-up wait
    logic                 trap_en;    // Trap enable
    logic [1:0]           trap_flags; // Sticky trap flags
    logic                 trap_pulse; // Trap event out
    logic [15:0]          err_cnt;    // Parity error count
    logic                 valid_prev; // Input loss edge detect
    logic                 main_prev;  // Status change detect
    logic [31:0]          prdata;     // Read data
  } rpcc_regs_t;

  localparam rpcc_regs_t REGS_RST = '{
    s1: '0, s2: '0, db_val: '0, db_cnt: '0, pb_prev: 1'b0, st: RPCC_INIT,
    wait_cnt: '0, trap_en: TRAP_EN_RST, trap_flags: 2'h0, trap_pulse: 1'b0,
    err_cnt: ERRCNT_RST, valid_prev: 1'b0, main_prev: 1'b0, prdata: 32'h0000_0000};

  logic [1:0] rst_sync_q; // Reset release synchroniser
  logic       rst_n;      // Synchronised reset
  rpcc_regs_t q;          // Registered state
  rpcc_regs_t d;          // Next state

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Decoded views of state
  logic       paired;   // Partner card fitted
  logic       allow;    // Changeover allowed
  logic       is_main;  // This card is main
  logic       valid;    // Valid input present
  logic       own_flt;  // Own input faulty for changeover
  logic [7:0] cfg;      // Config switch bank
  logic       wr_acc;   // APB write access
  logic       rd_setup; // APB read setup
  logic       mapped;   // Address hits a register
  logic       ctrl_wr;  // Control register write
  logic       sel_req;  // Local request to become main
  logic [1:0] in_state; // Reported input state
  logic [1:0] trap_set; // New trap events

  // Address decode shared by reads and writes
  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ERRCNT) || (a == OFS_TRAP);
  endfunction : hit

  assign cfg      = q.s2[S_CFG +: 8];
  assign paired   = q.s2[S_PRES];
  assign allow    = q.db_val[S_ALLOW];
  assign is_main  = (q.st == RPCC_MAIN);
  assign valid    = i_line.present;
  assign own_flt  = !valid || (cfg[CFG_AIS_CHG] && i_line.ais);
  assign mapped   = hit(paddr);
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign ctrl_wr  = wr_acc && (paddr == OFS_CTRL);
  // Button, external request and remote command, all gated by allow
  assign sel_req  = paired && allow && ((q.db_val[S_PB] && !q.pb_prev) || q.db_val[S_EXT]
                    || (ctrl_wr && pwdata[CTRL_SEL_MAIN]));
  // Lost input outranks alarm indication, which outranks framing
  assign in_state = !valid ? IN_ABSENT : i_line.ais ? IN_AIS :
                    i_line.framed ? IN_FRAMED : IN_PRESENT;
  assign trap_set = {q.trap_en && (q.main_prev != is_main),
                     q.trap_en && q.valid_prev && !valid};

  // Next-state logic
  always_comb
  begin
    d = q;
    // Pins pass two flops before use
    d.s1 = {i_config_switch_bank, i_partner.fault, i_partner.req, i_partner.main,
            !i_partner_present_n, i_slot_hi, i_pwr_ok, !i_ext_req_n, i_allow_sw,
            !i_change_pb_n};
    d.s2 = q.s1;
    // Debounce: level must hold for a full count before it is taken
    for (int k = 0; k < 3; k++)
    begin
      if (q.s2[k] == q.db_val[k])
        d.db_cnt[k] = '0;
      else if (q.db_cnt[k] == DB_W'(DB_CYC - 1))
      begin
        d.db_val[k] = q.s2[k];
        d.db_cnt[k] = '0;
      end
      else
        d.db_cnt[k] = q.db_cnt[k] + 1'b1;
    end
    d.pb_prev = q.db_val[S_PB];
    // Changeover state machine
    case (q.st)
      RPCC_INIT:
      begin
        // Upper slot waits twice as long so the pair cannot both claim
        if (q.wait_cnt == (q.s2[S_SLOT] ? SU_W'(2 * SU_CYC) : SU_W'(SU_CYC)))
          d.st = (paired && !q.s2[S_PMAIN] && !q.s2[S_PREQ]) ? RPCC_CLAIM : RPCC_STBY;
        else
          d.wait_cnt = q.wait_cnt + 1'b1;
      end
      RPCC_STBY:
      begin
        // Take over on request, or when the main card fails and ours is good
        if (sel_req || (paired && allow && q.s2[S_PFLT] && !own_flt && !q.s2[S_PMAIN]))
          d.st = RPCC_CLAIM;
      end
      RPCC_CLAIM:
      begin
        if (!allow || !paired)
          d.st = RPCC_STBY;
        else if (q.s2[S_PREQ] && q.s2[S_SLOT])
          d.st = RPCC_STBY;
        else if (!q.s2[S_PMAIN])
          d.st = RPCC_MAIN;
      end
      RPCC_MAIN:
      begin
        if (!paired)
          d.st = RPCC_STBY;
        else if (allow && (q.s2[S_PREQ] || (own_flt && !q.s2[S_PFLT])))
          d.st = RPCC_STBY;
      end
      default:
        d.st = RPCC_INIT;
    endcase
    // Trap events, sticky flags, set wins over clear
    d.valid_prev = valid;
    d.main_prev  = is_main;
    d.trap_pulse = |trap_set;
    if (wr_acc && (paddr == OFS_TRAP))
      d.trap_flags = (q.trap_flags & ~pwdata[1:0]) | trap_set;
    else
      d.trap_flags = q.trap_flags | trap_set;
    // Error counter, saturating, clear still counts a same-cycle error
    if (ctrl_wr && pwdata[CTRL_CNT_CLR])
      d.err_cnt = {15'h0000, i_line.fec_err};
    else if (i_line.fec_err && (q.err_cnt != 16'hffff))
      d.err_cnt = q.err_cnt + 16'h0001;
    if (ctrl_wr)
      d.trap_en = pwdata[CTRL_TRAP_EN];
    // Read data captured in setup so it is stable in access
    if (rd_setup)
    begin
      d.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CTRL:   d.prdata[CTRL_TRAP_EN] = q.trap_en;
        OFS_STATUS:
          d.prdata[12:0] = {paired, i_line.fec_seen, i_line.pkt_len, i_line.ts_found,
                            cfg[CFG_TX_HIGH] && !cfg[CFG_RATE_E3], cfg[CFG_RATE_E3],
                            in_state, paired, cfg[CFG_AIS_CHG], allow,
                            is_main};
        OFS_ERRCNT: d.prdata[15:0] = q.err_cnt;
        OFS_TRAP:   d.prdata[1:0] = q.trap_flags;
        default:    d.prdata = 32'h0000_0000;
      endcase
    end
    // Remote unit reset returns everything to the power-up state
    if (ctrl_wr && pwdata[CTRL_UNIT_RST])
      d = REGS_RST;
  end

  // State register
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= REGS_RST;
    else
      q <= d;
  end

  // APB answer: no wait states, error on unmapped address
  assign prdata  = q.prdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Handshake to partner
  assign o_link = '{main: is_main, req: (q.st == RPCC_CLAIM), fault: own_flt};

  // Indicators and alarms
  assign o_led_in_service = valid && (!paired || is_main);
  assign o_led_standby    = valid && paired && !is_main;
  assign o_led_data_loss  = !valid;
  assign o_led_ais        = i_line.ais;
  assign o_gen_alarm_n    = valid && !i_line.ais;
  assign o_pwr_alarm_n    = q.s2[S_PWR];
  assign o_tally_main_n   = !(paired && is_main);
  assign o_sel_own_input  = !paired || is_main;
  // Loss of input: alarm-indication pattern or silence
  assign o_tx_enable      = valid || !cfg[CFG_NO_INPUT];
  assign o_tx_ais         = !valid && !cfg[CFG_NO_INPUT];
  assign o_trap_event     = q.trap_pulse;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  property p_no_standby_alone;
    !paired |-> !o_led_standby;
  endproperty
  a_no_standby_alone: assert property (p_no_standby_alone)
    else $error("standby lit while alone");

  property p_button_alone;
    (!paired && q.st == RPCC_STBY) |=> (q.st != RPCC_CLAIM);
  endproperty
  a_button_alone: assert property (p_button_alone)
    else $error("claim while alone");

  property p_alarm;
    (!i_line.present || i_line.ais) |-> !o_gen_alarm_n && (o_led_data_loss || o_led_ais);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm not raised");

  property p_inhibit;
    (!allow && paired && d.st != RPCC_INIT && q.st != RPCC_CLAIM && !ctrl_wr) |=>
      (is_main == $past(is_main));
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("change while inhibited");

  property p_atomic;
    (q.st == RPCC_CLAIM && q.s2[S_PMAIN]) |=> !is_main;
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("main while partner main");

  property p_tally;
    (paired && is_main) |-> !o_tally_main_n && o_link.main && !o_led_standby;
  endproperty
  a_tally: assert property (p_tally)
    else $error("tally wrong");

  property p_cnt_clr;
    (ctrl_wr && pwdata[CTRL_CNT_CLR] && !pwdata[CTRL_UNIT_RST]) |=> (q.err_cnt <= 16'h0001);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr)
    else $error("counter not cleared");

  property p_trap_loss;
    (q.trap_en && q.valid_prev && !valid && !ctrl_wr) |=> q.trap_flags[TRAP_LOSS] && q.trap_pulse;
  endproperty
  a_trap_loss: assert property (p_trap_loss)
    else $error("loss trap missing");

  property p_unit_reset;
    (ctrl_wr && pwdata[CTRL_UNIT_RST]) |=> (q.st == RPCC_INIT) && !q.trap_en;
  endproperty
  a_unit_reset: assert property (p_unit_reset)
    else $error("unit reset ignored");

  property p_no_input_off;
    (!i_line.present && cfg[CFG_NO_INPUT]) |-> !o_tx_enable && !o_tx_ais;
  endproperty
  a_no_input_off: assert property (p_no_input_off)
    else $error("output not disabled");

  // Indicator, gating and counter checks
  property p_indicators;
    (o_led_data_loss == !i_line.present) && (o_led_ais == i_line.ais);
  endproperty
  a_indicators: assert property (p_indicators)
    else $error("fault indicators wrong");

  property p_standby_view;
    (paired && !is_main) |-> (o_led_standby == valid) && !o_led_in_service;
  endproperty
  a_standby_view: assert property (p_standby_view)
    else $error("standby indicator wrong");

  property p_claim_gate;
    (q.st == RPCC_STBY && d.st == RPCC_CLAIM) |-> paired && allow;
  endproperty
  a_claim_gate: assert property (p_claim_gate)
    else $error("claim while inhibited or alone");

  property p_yield_fault;
    (is_main && paired && allow && own_flt && !q.s2[S_PFLT] && !ctrl_wr) |=> !is_main;
  endproperty
  a_yield_fault: assert property (p_yield_fault)
    else $error("main kept a faulty input");

  property p_remote_sel;
    (ctrl_wr && pwdata[CTRL_SEL_MAIN] && !pwdata[CTRL_UNIT_RST] && paired && allow &&
     q.st == RPCC_STBY) |=> (q.st == RPCC_CLAIM);
  endproperty
  a_remote_sel: assert property (p_remote_sel)
    else $error("remote select ignored");

  property p_rate_level;
    (rd_setup && paddr == OFS_STATUS && cfg[CFG_RATE_E3]) |=> !prdata[7];
  endproperty
  a_rate_level: assert property (p_rate_level)
    else $error("level shown at lower rate");

  property p_trap_off;
    !q.trap_en |=> !q.trap_pulse;
  endproperty
  a_trap_off: assert property (p_trap_off)
    else $error("trap while disabled");

  property p_err_step;
    (i_line.fec_err && !ctrl_wr && q.err_cnt != 16'hffff) |=>
      (q.err_cnt == $past(q.err_cnt) + 16'h0001);
  endproperty
  a_err_step: assert property (p_err_step)
    else $error("error not counted");

  c_take_main: cover property (q.st == RPCC_CLAIM ##1 q.st == RPCC_MAIN);
  c_yield:     cover property (is_main ##1 !is_main);
  c_trap:      cover property (q.trap_pulse);
  c_far_fault: cover property (q.st == RPCC_STBY && q.s2[S_PFLT] ##1 q.st == RPCC_CLAIM);
endmodule : rpcc_ctrl

// File: test/rpcc_partner.sv
`timescale 1ns/1ns
// Behavioural companion card of the redundant pair
module rpcc_partner
  import rpcc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire rpcc_link_t i_peer,  // Handshake from the card under test
  input  wire logic       i_claim, // Bench asks this card to go main
  input  wire logic       i_fault, // This card's own input is faulty
  output rpcc_link_t      o_link   // Handshake towards the card under test
);
  // Starts standby; claims on command or peer fault, yields on peer claim
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_link <= 3'h0;
    else
    begin
      o_link.fault <= i_fault;
      if (o_link.main)
      begin
        // Yield to a peer claim or to an own fault
        if (i_peer.req || (i_fault && !i_peer.fault))
          o_link.main <= 1'h0;
      end
      else if (o_link.req)
      begin
        // Back off in a tie, or once the cause has gone
        if (i_peer.req || !(i_claim || (i_peer.fault && !i_fault)))
          o_link.req <= 1'h0;
        else if (!i_peer.main)
        begin
          o_link.main <= 1'h1;
          o_link.req  <= 1'h0;
        end
      end
      else if (i_claim || (i_peer.fault && !i_fault))
        o_link.req <= 1'h1;
    end
  end
endmodule : rpcc_partner

// File: test/tb.sv
`timescale 1ns/1ns
module tb
  import rpcc_pkg::*;
;
  logic        i_clk = 1'h0, i_rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, cfg = 8'h00;  // Bus address, switch bank
  logic [31:0] pwdata = 32'h0, prdata, r;    // Bus data, last read
  logic        pready, pslverr, e, claim = 1'h0, slot = 1'h0, pflt = 1'h0; // Strap, far fault
  logic        pb_n = 1'h1, allow = 1'h1, ext_n = 1'h1, pwr = 1'h1, pres_n = 1'h0;
  logic        in_svc, stby, dloss, ais_led, gen_n, pwr_n, tally_n, own, tx_en, tx_ais, trap;
  rpcc_line_t  ln = 8'h80;                   // Line monitor, input present
  rpcc_link_t  link, plink;                  // Both halves of the handshake
  int          mismatches = 0, num_checks = 0, tp = 0;
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  rpcc_ctrl #(.DB_CYC(4), .SU_CYC(20)) u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_change_pb_n(pb_n), .i_allow_sw(allow), .i_ext_req_n(ext_n), .i_pwr_ok(pwr),
    .i_slot_hi(slot), .i_config_switch_bank(cfg), .i_partner_present_n(pres_n),
    .i_partner(plink), .o_link(link), .i_line(ln), .o_led_in_service(in_svc),
    .o_led_standby(stby), .o_led_data_loss(dloss), .o_led_ais(ais_led),
    .o_gen_alarm_n(gen_n), .o_pwr_alarm_n(pwr_n), .o_tally_main_n(tally_n),
    .o_sel_own_input(own), .o_tx_enable(tx_en), .o_tx_ais(tx_ais), .o_trap_event(trap));
  rpcc_partner u_partner (.i_clk(i_clk), .i_rstn(i_rstn), .i_peer(link),
    .i_claim(claim), .i_fault(pflt), .o_link(plink));
  // Compare and count
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // Bounded wait for our main flag to reach a level
  task automatic wt(input logic v);
    for (int k = 0; k < 300 && link.main !== v; k++) @(posedge i_clk);
  endtask : wt
  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'h1;
    @(posedge i_clk);
    while (pready !== 1'h1) @(posedge i_clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge i_clk);
  endtask : apb
  // Random line state; first three force the input lost, present, lost
  function automatic rpcc_line_t rline(input int k);
    rpcc_line_t l;
    l = rpcc_line_t'(8'($urandom));
    l.fec_err = 1'h0;
    if (k < 3) l.present = k[0];
    if (!l.present) l.ais = 1'h0;
    return l;
  endfunction : rline
  // Expected status word for a paired card with partner fitted
  function automatic logic [31:0] st_exp(input logic m);
    logic [1:0] s;
    s = !ln.present ? IN_ABSENT : ln.ais ? IN_AIS : ln.framed ? IN_FRAMED : IN_PRESENT;
    return {19'h0, 1'h1, ln.fec_seen, ln.pkt_len, ln.ts_found,
            cfg[CFG_TX_HIGH] & !cfg[CFG_RATE_E3], cfg[CFG_RATE_E3], s, 1'h1,
            cfg[CFG_AIS_CHG], allow, m};
  endfunction : st_exp
  // Both cards must never be main together
  always @(posedge i_clk)
  begin
    if (i_rstn) chk("both main", link.main & plink.main, 1'h0);
    if (trap === 1'h1) tp++;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'h42c4));
    cyc(8);
    i_rstn <= 1'h1;
    cyc(60);
    chk("power-up", {link.main, plink.main, tally_n}, 3'h4);
    chk("power ok", pwr_n, 1'h1);
    allow <= 1'h0;
    cyc(12);
    for (int k = 0; k < 16; k++)
    begin
      ln  <= rline(k);
      cfg <= 8'($urandom);
      cyc(3);
      chk("leds", {in_svc, stby, dloss, ais_led}, {ln.present, 1'h0, !ln.present, ln.ais});
      chk("gen alarm", gen_n, !(!ln.present || ln.ais));
      if (!ln.present) chk("tx path", cfg[CFG_NO_INPUT] ? tx_en : tx_ais, !cfg[CFG_NO_INPUT]);
      apb(1'h0, OFS_STATUS, 32'h0);
      chk("status", r, st_exp(1'h1));
      chk("inhibit hold", link.main, 1'h1);
    end
    pwr <= 1'h0;
    cyc(4);
    chk("power alarm", pwr_n, 1'h0);
    pwr   <= 1'h1;
    ln    <= 8'h80;
    cfg   <= 8'h00;
    allow <= 1'h1;
    apb(1'h1, OFS_CTRL, 32'h8);
    apb(1'h0, OFS_CTRL, 32'h0);
    chk("trap enable", r, 32'h8);
    apb(1'h1, OFS_TRAP, 32'h3);
    cyc(12);
    ln <= 8'h00;
    wt(1'h0);
    cyc(5);
    chk("auto change", {link.main, plink.main}, 2'h1);
    apb(1'h0, OFS_TRAP, 32'h0);
    chk("trap flags", r, 32'h3);
    chk("trap pulse", tp > 0, 1'h1);
    apb(1'h1, OFS_TRAP, 32'h3);
    apb(1'h0, OFS_TRAP, 32'h0);
    chk("trap clear", r, 32'h0);
    ln <= 8'h80;
    cyc(5);
    chk("standby view", {in_svc, stby, tally_n, own}, 4'h6);
    // A press shorter than the debounce count must not claim
    pb_n <= 1'h0;
    cyc(2);
    pb_n <= 1'h1;
    cyc(10);
    chk("glitch ignored", link.main, 1'h0);
    // Far card input fails: it yields and this card takes over
    pflt <= 1'h1;
    wt(1'h1);
    cyc(5);
    chk("partner fault", {link.main, plink.main}, 2'h2);
    pflt  <= 1'h0;
    claim <= 1'h1;
    wt(1'h0);
    cyc(5);
    claim <= 1'h0;
    pb_n <= 1'h0;
    cyc(12);
    pb_n <= 1'h1;
    wt(1'h1);
    cyc(5);
    chk("manual claim", {link.main, plink.main, own}, 3'h5);
    claim <= 1'h1;
    wt(1'h0);
    cyc(5);
    claim <= 1'h0;
    allow <= 1'h0;
    cyc(12);
    apb(1'h1, OFS_CTRL, 32'h9);
    pb_n  <= 1'h0;
    ext_n <= 1'h0;
    cyc(12);
    pb_n  <= 1'h1;
    ext_n <= 1'h1;
    cyc(20);
    chk("inhibit blocks", link.main, 1'h0);
    allow <= 1'h1;
    cyc(12);
    apb(1'h1, OFS_CTRL, 32'h9);
    wt(1'h1);
    chk("remote main", link.main, 1'h1);
    claim <= 1'h1;
    wt(1'h0);
    cyc(5);
    claim <= 1'h0;
    ext_n <= 1'h0;
    wt(1'h1);
    chk("external req", link.main, 1'h1);
    ext_n <= 1'h1;
    for (int k = 0; k < 5; k++)
    begin
      ln <= 8'h81;
      @(posedge i_clk);
      ln <= 8'h80;
      cyc(2);
    end
    apb(1'h0, OFS_ERRCNT, 32'h0);
    chk("error count", r, 32'h5);
    apb(1'h1, OFS_CTRL, 32'h4);
    apb(1'h0, OFS_ERRCNT, 32'h0);
    chk("count clear", r, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped err", e, 1'h1);
    chk("unmapped data", r, 32'h0);
    slot <= 1'h1;
    apb(1'h1, OFS_CTRL, 32'ha);
    cyc(2);
    chk("unit reset", link.main, 1'h0);
    apb(1'h0, OFS_CTRL, 32'h0);
    chk("reset trap en", r, 32'h0);
    // Upper slot waits twice the start-up span before it claims
    cyc(25);
    chk("slot wait", link.main, 1'h0);
    cyc(35);
    chk("rejoin main", link.main, 1'h1);
    pres_n <= 1'h1;
    cyc(5);
    pb_n <= 1'h0;
    cyc(12);
    pb_n <= 1'h1;
    cyc(10);
    chk("stand-alone", {in_svc, stby, tally_n, own}, 4'hb);
    test_done();
  end
endmodule : tb
